// ### include/ability_pkg.sv
package ability_pkg;

  // Management register numbers
  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_ADVERT  = 5'h04;
  localparam logic [4:0] REG_PARTNER = 5'h05;

  // Control register bits that act as advertisement triggers
  localparam int CTRL_SOFT_RESET_BIT = 15;
  localparam int CTRL_POWER_DOWN_BIT = 11;
  localparam int CTRL_AN_RESTART_BIT = 9;

  // Advertisement field positions
  localparam int ADV_NEXT_PAGE_BIT    = 15;
  localparam int ADV_REMOTE_FAULT_BIT = 13;
  localparam int ADV_EXT_NEXT_BIT     = 12;
  localparam int ADV_ASYM_PAUSE_BIT   = 11;
  localparam int ADV_PAUSE_BIT        = 10;
  localparam int ADV_FAST_FULL_BIT    = 8;
  localparam int ADV_FAST_HALF_BIT    = 7;
  localparam int ADV_SLOW_FULL_BIT    = 6;
  localparam int ADV_SLOW_HALF_BIT    = 5;
  localparam logic [4:0] ADV_SELECTOR = 5'h01;

  // Partner field positions
  localparam int PTR_NEXT_PAGE_BIT = 15;
  localparam int PTR_RESERVED_BIT  = 12;
  localparam int PTR_FAST_BIT      = 7;
  localparam int PTR_SLOW_HALF_BIT = 5;
  localparam logic [15:0] PTR_RESET = 16'h0000;

  // Management frame layout
  localparam logic [1:0] OP_WRITE  = 2'b01;
  localparam logic [1:0] OP_READ   = 2'b10;
  localparam logic [4:0] OP_LAST   = 5'h01;
  localparam logic [4:0] ADDR_LAST = 5'h04;
  localparam logic [4:0] DATA_LAST = 5'h0F;

  typedef enum logic [2:0] {M_IDLE, M_START, M_OP, M_PHYAD, M_REGAD, M_TA, M_DATA} mgmt_state_t;

  typedef struct packed {
    logic next_page;
    logic remote_fault;
    logic ext_next_page;
    logic asym_pause;
    logic pause;
    logic adv_fast_full;
    logic adv_fast_half;
    logic adv_slow_full;
    logic adv_slow_half;
  } adv_cfg_t;

  localparam adv_cfg_t ADV_RESET = '{next_page: 1'b0, remote_fault: 1'b0, ext_next_page: 1'b1,
                                     asym_pause: 1'b1, pause: 1'b1, adv_fast_full: 1'b1,
                                     adv_fast_half: 1'b1, adv_slow_full: 1'b1, adv_slow_half: 1'b1};

  // Events from the negotiation engine
  typedef struct packed {
    logic        page_valid;
    logic [15:0] page;
    logic        an_complete;
    logic        pd_fast_link;
    logic        pd_slow_link;
  } partner_evt_t;

  typedef struct packed {
    mgmt_state_t st;
    logic [4:0]  cnt;
    logic [1:0]  op;
    logic [4:0]  phyad;
    logic [4:0]  regad;
    logic [15:0] shift;
    logic        mdio_out;
    logic        mdio_oe;
    adv_cfg_t    shown;
    adv_cfg_t    active;
    logic [15:0] partner;
    logic [15:0] partner_hold;
    logic        hold_pending;
    logic        link_prev;
    logic        apply;
  } bank_state_t;

  function automatic logic [15:0] pack_advert(input adv_cfg_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[ADV_NEXT_PAGE_BIT]    = c.next_page;
    w[ADV_REMOTE_FAULT_BIT] = c.remote_fault;
    w[ADV_EXT_NEXT_BIT]     = c.ext_next_page;
    w[ADV_ASYM_PAUSE_BIT]   = c.asym_pause;
    w[ADV_PAUSE_BIT]        = c.pause;
    w[ADV_FAST_FULL_BIT]    = c.adv_fast_full;
    w[ADV_FAST_HALF_BIT]    = c.adv_fast_half;
    w[ADV_SLOW_FULL_BIT]    = c.adv_slow_full;
    w[ADV_SLOW_HALF_BIT]    = c.adv_slow_half;
    w[4:0]                  = ADV_SELECTOR;
    return w;
  endfunction

endpackage

// ### rtl/mgmt_pin_sync.sv
`timescale 1ns/1ps
module mgmt_pin_sync #(
  parameter int STAGES = 2
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // Raw pins
  input  wire logic mdc,
  input  wire logic mdio_in,
  // Synchronised view
  output logic      mdc_rise,
  output logic      mdio_bit
);

  typedef struct packed {
    logic [STAGES:0]   clk_q;
    logic [STAGES-1:0] dat_q;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  // Fewer than two stages would let a metastable pin value reach the frame logic
  if (STAGES < 2)
  begin
    $error("mgmt_pin_sync needs at least two stages");
  end

  // Only the last stages are looked at; stage 0 feeds stage 1 alone
  always_comb
  begin
    next_s       = s;
    next_s.clk_q = {s.clk_q[STAGES-1:0], mdc};
    next_s.dat_q = {s.dat_q[STAGES-2:0], mdio_in};
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      s <= '0;
    else
      s <= next_s;
  end

  assign mdc_rise = s.clk_q[STAGES-1] & ~s.clk_q[STAGES];
  assign mdio_bit = s.dat_q[STAGES-1];

endmodule

// ### rtl/autoneg_ability_registers.sv
`timescale 1ns/1ps
// Notes on behaviour
// (RL1) Register 4 holds the local abilities sent to the partner.
// (RL2) Bit 13 writable remote fault, reset 0; bit 14 reserved reads 0.
// (RL3) Bit 12 writable, reset 1, extended next page capability.
// (RL4) Bit 11 writable, reset 1, asymmetric pause advertised.
// (RL5) Bit 10 writable, reset 1, pause; bit 15 next page, reset 0.
// (RL6) Bit 9 fixed 0: four-pair 100 Mb/s not supported.
// (RL7) Bits 8..5 writable, reset 1: the four speed/duplex abilities.
// (RL8) Starred bits read back at once but act only after a trigger.
// (RL9) Writing control bit 15 (soft reset) applies pending settings.
// (RL10) Writing control bit 9 (restart negotiation) applies pending settings.
// (RL11) Leaving power-down through control bit 11 applies pending settings.
// (RL12) Register 5 is read-only partner abilities, reset all zero.
// (RL13) With next pages, partner contents replaced when negotiation completes.
// (RL14) Partner bit 15 flags primary (0) or protocol page (1).
// (RL15) Partner bit 14 is the partner acknowledge.
// (RL16) Partner bit 13 is partner remote fault; bit 12 reserved.
// (RL17) Partner bit 11 reports partner asymmetric pause.
// (RL18) Partner bit 10 reports partner pause.
// (RL19) Partner bits 9, 8, 6 report received abilities.
// (RL20) Partner bit 7 also set by 100 Mb/s parallel detection.
// (RL21) Partner bit 5 also set by 10 Mb/s parallel detection.
// (RL22) Partner bits 4..0 hold the partner selector, reset zero.
// (RL23) Local selector bits 4..0 read-only, value 00001.
module autoneg_ability_registers
  import ability_pkg::*;
(
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  // Management pins
  input  wire logic                      mdc,
  input  wire logic                      mdio_in,
  output logic                           mdio_out,
  output logic                           mdio_oe,
  // Station address, held stable by the strap latch
  input  wire logic [4:0]                phy_addr,
  // Port state from the rest of the PHY
  input  wire logic                      power_down,
  input  wire logic                      link_up,
  // Negotiation engine
  input  wire ability_pkg::partner_evt_t partner_evt,
  output logic [15:0]                    active_advert,
  output logic                           advert_apply,
  output logic [15:0]                    partner_ability
);
  import ability_pkg::*;

  bank_state_t s;
  bank_state_t next_s;
  logic        mdc_rise;
  logic        mdio_bit;
  logic        addr_hit;
  logic        read_hit;
  logic        frame_end;
  logic [15:0] wdata;
  logic        ctrl_write;
  logic        trigger;
  logic [15:0] read_word;
  logic [15:0] rx_page;

  mgmt_pin_sync #(
    .STAGES   (2)
  ) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .mdc      (mdc),
    .mdio_in  (mdio_in),
    .mdc_rise (mdc_rise),
    .mdio_bit (mdio_bit)
  );

  // Register 5 is served only from the captured copy, so reads never see a half update
  always_comb
  begin
    read_word = 16'h0000;
    if (s.regad == REG_ADVERT)
      read_word = pack_advert(s.shown);  // [RL1] [RL6] [RL23]
    else if (s.regad == REG_PARTNER)
      read_word = s.partner;  // [RL12]
  end

  assign addr_hit   = (s.phyad == phy_addr);
  assign read_hit   = addr_hit && (s.op == OP_READ) && ((s.regad == REG_ADVERT) || (s.regad == REG_PARTNER));
  assign frame_end  = mdc_rise && (s.st == M_DATA) && (s.cnt == DATA_LAST);
  assign wdata      = {s.shift[14:0], mdio_bit};
  assign ctrl_write = frame_end && addr_hit && (s.op == OP_WRITE) && (s.regad == REG_CONTROL);

  // Any of the four events makes the pending advertisement live
  always_comb
  begin
    trigger = 1'b0;
    if (ctrl_write && wdata[CTRL_SOFT_RESET_BIT])
      trigger = 1'b1;  // [RL9]
    if (ctrl_write && wdata[CTRL_AN_RESTART_BIT])
      trigger = 1'b1;  // [RL10]
    if (ctrl_write && power_down && !wdata[CTRL_POWER_DOWN_BIT])
      trigger = 1'b1;  // [RL11]
    if (s.link_prev && !link_up)
      trigger = 1'b1;  // [RL8]
  end

  // Reserved partner bit never stored
  always_comb
  begin
    rx_page                   = partner_evt.page;
    rx_page[PTR_RESERVED_BIT] = 1'b0;  // [RL16]
  end

  always_comb
  begin
    next_s           = s;
    next_s.apply     = 1'b0;
    next_s.link_prev = link_up;

    // Frame engine: preamble is optional, a zero on an idle line opens a frame
    if (mdc_rise)
    begin
      case (s.st)
        M_IDLE:
        begin
          next_s.mdio_oe = 1'b0;
          if (!mdio_bit)
            next_s.st = M_START;
        end
        M_START:
        begin
          next_s.cnt = 5'h00;
          next_s.st  = mdio_bit ? M_OP : M_IDLE;
        end
        M_OP:
        begin
          next_s.op = {s.op[0], mdio_bit};
          if (s.cnt == OP_LAST)
          begin
            next_s.cnt = 5'h00;
            next_s.st  = M_PHYAD;
          end
          else
            next_s.cnt = s.cnt + 5'h01;
        end
        M_PHYAD:
        begin
          next_s.phyad = {s.phyad[3:0], mdio_bit};
          if (s.cnt == ADDR_LAST)
          begin
            next_s.cnt = 5'h00;
            next_s.st  = M_REGAD;
          end
          else
            next_s.cnt = s.cnt + 5'h01;
        end
        M_REGAD:
        begin
          next_s.regad = {s.regad[3:0], mdio_bit};
          if (s.cnt == ADDR_LAST)
          begin
            next_s.cnt = 5'h00;
            next_s.st  = M_TA;
          end
          else
            next_s.cnt = s.cnt + 5'h01;
        end
        M_TA:
        begin
          // First turnaround bit belongs to the station, the second is ours on a read
          if (s.cnt == 5'h00)
          begin
            next_s.cnt = 5'h01;
            if (read_hit)
            begin
              next_s.mdio_oe  = 1'b1;
              next_s.mdio_out = 1'b0;
            end
          end
          else
          begin
            next_s.cnt = 5'h00;
            next_s.st  = M_DATA;
            if (read_hit)
            begin
              next_s.shift    = read_word;
              next_s.mdio_out = read_word[15];
            end
          end
        end
        M_DATA:
        begin
          if (read_hit)
          begin
            next_s.shift    = {s.shift[14:0], 1'b0};
            next_s.mdio_out = s.shift[14];
          end
          else
            next_s.shift = wdata;
          if (s.cnt == DATA_LAST)
          begin
            next_s.st       = M_IDLE;
            next_s.cnt      = 5'h00;
            next_s.mdio_oe  = 1'b0;
            next_s.mdio_out = 1'b0;
          end
          else
            next_s.cnt = s.cnt + 5'h01;
        end
        default:
        begin
          next_s.st      = M_IDLE;
          next_s.mdio_oe = 1'b0;
        end
      endcase
    end

    // Advertisement write updates the readable copy at once
    if (frame_end && addr_hit && (s.op == OP_WRITE) && (s.regad == REG_ADVERT))
    begin
      next_s.shown.next_page     = wdata[ADV_NEXT_PAGE_BIT];     // [RL5]
      next_s.shown.remote_fault  = wdata[ADV_REMOTE_FAULT_BIT];  // [RL2]
      next_s.shown.ext_next_page = wdata[ADV_EXT_NEXT_BIT];      // [RL3]
      next_s.shown.asym_pause    = wdata[ADV_ASYM_PAUSE_BIT];    // [RL4]
      next_s.shown.pause         = wdata[ADV_PAUSE_BIT];         // [RL5]
      next_s.shown.adv_fast_full = wdata[ADV_FAST_FULL_BIT];     // [RL7]
      next_s.shown.adv_fast_half = wdata[ADV_FAST_HALF_BIT];     // [RL7]
      next_s.shown.adv_slow_full = wdata[ADV_SLOW_FULL_BIT];     // [RL7]
      next_s.shown.adv_slow_half = wdata[ADV_SLOW_HALF_BIT];     // [RL7]
    end

    // Remote fault and extended next page act at once; the rest wait for a trigger
    next_s.active.remote_fault  = next_s.shown.remote_fault;   // [RL2]
    next_s.active.ext_next_page = next_s.shown.ext_next_page;  // [RL3]
    if (trigger)
    begin
      next_s.active = next_s.shown;  // [RL8]
      next_s.apply  = 1'b1;
    end

    // Soft reset empties the partner view before this cycle's events land
    if (ctrl_write && wdata[CTRL_SOFT_RESET_BIT])
    begin
      next_s.partner      = PTR_RESET;
      next_s.hold_pending = 1'b0;
    end

    // With next pages in play the base page waits for completion
    if (partner_evt.page_valid)
    begin
      if (rx_page[PTR_NEXT_PAGE_BIT] || s.active.next_page)
      begin
        next_s.partner_hold = rx_page;  // [RL13]
        next_s.hold_pending = 1'b1;
      end
      else
        next_s.partner = rx_page;  // [RL14] [RL15] [RL16] [RL17] [RL18] [RL19] [RL22]
    end
    else if (partner_evt.an_complete && s.hold_pending)
    begin
      next_s.partner      = s.partner_hold;  // [RL13]
      next_s.hold_pending = 1'b0;
    end

    // Parallel detection sets its bit even against a clearing soft reset
    if (partner_evt.pd_fast_link)
      next_s.partner[PTR_FAST_BIT] = 1'b1;  // [RL20]
    if (partner_evt.pd_slow_link)
      next_s.partner[PTR_SLOW_HALF_BIT] = 1'b1;  // [RL21]
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      s              <= '0;
      s.st           <= M_IDLE;
      s.shown        <= ADV_RESET;  // [RL2] [RL3] [RL4] [RL5] [RL7]
      s.active       <= ADV_RESET;
      s.partner      <= PTR_RESET;  // [RL12] [RL22]
      s.partner_hold <= PTR_RESET;
    end
    else
      s <= next_s;
  end

  assign mdio_out        = s.mdio_out;
  assign mdio_oe         = s.mdio_oe;
  assign active_advert   = pack_advert(s.active);
  assign advert_apply    = s.apply;
  assign partner_ability = s.partner;

endmodule

// ### testbench/ability_properties.sv
`timescale 1ns/1ps
module ability_checker
  import ability_pkg::*;
(
  // Clock and reset
  input wire logic                      core_clk,
  input wire logic                      rstn,
  // Watched ports
  input wire logic                      mdio_out,
  input wire logic                      mdio_oe,
  input wire logic                      link_up,
  input wire ability_pkg::partner_evt_t partner_evt,
  input wire logic [15:0]               active_advert,
  input wire logic                      advert_apply,
  input wire logic [15:0]               partner_ability
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  reset_vals_a: assert property (disable iff (1'b0) !rstn |=> active_advert == 16'h1DE1
    && partner_ability == 16'h0000 && !advert_apply && !mdio_oe) else $error("bad reset value");
  fixed_sel_a: assert property (active_advert[4:0] == ADV_SELECTOR
    && !active_advert[14] && !active_advert[9]) else $error("bad fixed bits");
  link_fall_a: assert property ($fell(link_up) |=> advert_apply) else $error("no apply");
  apply_only_a: assert property (!$stable(active_advert[11:0]) || !$stable(active_advert[15])
    |-> advert_apply) else $error("change without apply");
  pd_fast_a: assert property (partner_evt.pd_fast_link |=> partner_ability[7]) else $error("fast");
  pd_slow_a: assert property (partner_evt.pd_slow_link |=> partner_ability[5]) else $error("slow");
  page_load_a: assert property (partner_evt.page_valid && !partner_evt.page[15] && !active_advert[15]
    && !partner_evt.pd_fast_link && !partner_evt.pd_slow_link
    |=> partner_ability == ($past(partner_evt.page) & 16'hEFFF)) else $error("page not loaded");
  ta_low_a: assert property ($rose(mdio_oe) |-> !mdio_out ##1 mdio_oe [*7]) else $error("short read");
endmodule

// ### testbench/mdio_station.sv
`timescale 1ns/1ps
module mdio_station
  import ability_pkg::*;
(
  // Clock
  input  wire logic core_clk,
  // Management pins
  output logic      mdc,
  output logic      mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  logic drv_oe = 1'b0;
  logic drv_bit = 1'b1;

  // Pull-up: an unanswered read shows all ones
  assign mdio_in = mdio_oe ? mdio_out : (drv_oe ? drv_bit : 1'b1);
  initial mdc = 1'b0;

  // Eight core clocks a bit; mdc stands low between frames
  task automatic bit_cyc(input logic b, input logic oe, output logic s);
    mdc <= 1'b0;
    drv_bit <= b;
    drv_oe <= oe;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    s = mdio_in;
    @(posedge core_clk);
    mdc <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    logic        s;
    f = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--)
    begin
      // Line let go from turnaround on in a read
      bit_cyc(f[i], !(op == OP_READ && i < 18), s);
      if (i < 16)
        rd[i] = s;
    end
    mdc <= 1'b0;
    drv_oe <= 1'b0;
    @(posedge core_clk);
  endtask
endmodule

// ### testbench/autoneg_ability_registers_bench.sv
`timescale 1ns/1ps
module autoneg_ability_registers_bench;
  import ability_pkg::*;
  localparam logic [4:0] ADDR = 5'h03;
  logic         core_clk = 1'b0;
  logic         rstn = 1'b0;
  logic         mdc;
  logic         mdio_in;
  logic         mdio_out;
  logic         mdio_oe;
  logic         power_down = 1'b0;
  logic         link_up = 1'b1;
  partner_evt_t evt = '0;
  logic [15:0]  active_advert;
  logic         advert_apply;
  logic [15:0]  partner_ability;
  int           mismatches = 0;
  int           check_count = 0;
  int           applies = 0;

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (advert_apply === 1'b1)
      applies <= applies + 1;

  autoneg_ability_registers uut (.core_clk(core_clk), .rstn(rstn), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(ADDR), .power_down(power_down), .link_up(link_up),
    .partner_evt(evt), .active_advert(active_advert), .advert_apply(advert_apply),
    .partner_ability(partner_ability));
  mdio_station stn (.core_clk(core_clk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    stn.frame(OP_WRITE, ADDR, ra, d, x);
    repeat (4) @(posedge core_clk);
  endtask

  task automatic rd(input logic [4:0] pa, input logic [4:0] ra, output logic [15:0] d);
    stn.frame(OP_READ, pa, ra, 16'h0000, d);
  endtask

  task automatic pulse(input partner_evt_t e);
    evt <= e;
    @(posedge core_clk);
    evt <= '0;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic fire(input int i);
    if (i == 0)
    begin
      link_up <= 1'b0;
      @(posedge core_clk);
      link_up <= 1'b1;
    end
    else if (i == 3)
    begin
      power_down <= 1'b1;
      wr(REG_CONTROL, 16'h0000);
      power_down <= 1'b0;
    end
    else
      wr(REG_CONTROL, i == 1 ? 16'h8000 : 16'h0200);
    repeat (3) @(posedge core_clk);
  endtask

  task automatic t_reset();
    logic [15:0] d;
    rd(ADDR, REG_ADVERT, d);
    check(d, 16'h1DE1);
    rd(ADDR, REG_PARTNER, d);
    check(d, 16'h0000);
    rd(ADDR + 5'h01, REG_ADVERT, d);
    check(d, 16'hFFFF);
    rd(ADDR, REG_CONTROL, d);
    check(d, 16'hFFFF);
  endtask

  task automatic t_triggers();
    logic [15:0] v [4] = '{16'hFFFF, 16'h0000, 16'hA5A5, 16'h5A5A};
    logic [15:0] d;
    logic [15:0] exp;
    logic [15:0] old;
    int          n;
    for (int i = 0; i < 4; i++)
    begin
      exp = (v[i] & 16'hBDE0) | 16'h0001;
      old = active_advert;
      n = applies;
      wr(REG_ADVERT, v[i]);
      rd(ADDR, REG_ADVERT, d);
      check(d, exp);
      check(active_advert, (old & 16'hCFFF) | (exp & 16'h3000));
      fire(i);
      check(active_advert, exp);
      check(16'(applies - n), 16'h0001);
    end
    n = applies;
    wr(REG_CONTROL, 16'h0000);
    check(16'(applies - n), 16'h0000);
  endtask

  task automatic t_partner();
    logic [15:0] d;
    pulse('{1'b1, 16'h7FFF, 1'b0, 1'b0, 1'b0});
    check(partner_ability, 16'h6FFF);
    wr(REG_PARTNER, 16'h0000);
    rd(ADDR, REG_PARTNER, d);
    check(d, 16'h6FFF);
    pulse('{1'b1, 16'h8421, 1'b0, 1'b0, 1'b0});
    check(partner_ability, 16'h6FFF);
    pulse('{1'b0, 16'h0000, 1'b1, 1'b0, 1'b0});
    check(partner_ability, 16'h8421);
    wr(REG_CONTROL, 16'h8000);
    check(partner_ability, 16'h0000);
    pulse('{1'b0, 16'h0000, 1'b0, 1'b1, 1'b0});
    check(partner_ability, 16'h0080);
    pulse('{1'b0, 16'h0000, 1'b0, 1'b0, 1'b1});
    check(partner_ability, 16'h00A0);
  endtask

  initial
  begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_triggers();
    t_partner();
    test_done();
  end

  initial
  begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    test_done();
  end
endmodule

bind autoneg_ability_registers ability_checker chk (.core_clk(core_clk), .rstn(rstn), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe), .link_up(link_up), .partner_evt(partner_evt), .active_advert(active_advert),
  .advert_apply(advert_apply), .partner_ability(partner_ability));
